// >>> hw/car_cfg_space.sv
`timescale 1ns/10ps
`default_nettype none
module car_cfg_space #(
	parameter logic [15:0] DEV_CODE = 16'h0001,
	parameter bit HUB = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Access
	input wire logic wr,
	input wire logic [5:0] reg_idx,
	input wire logic [3:0] be,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata,
	// State to router
	output logic [7:0] bus_num,
	output logic [31:0] limits
);
	logic [31:0] cmd_q;
	logic [7:0] bus_num_q;
	logic [31:0] lim_q;

	// --------------------------------------------------------------
	// Writable registers
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= car_pkg::CAR_CMD_RESET; // RULE10
			bus_num_q <= car_pkg::CAR_BUS_NUM_RESET; // RULE10
			lim_q <= car_pkg::CAR_LIMITS_RESET; // RULE10
		end else if (wr) begin
			for (int i = 0; i < 4; i++) begin
				if (be[i]) begin
					if (reg_idx == car_pkg::CAR_REG_CMD) begin
						cmd_q[i*8 +: 8] <= wdata[i*8 +: 8];
					end
					if (HUB && reg_idx == car_pkg::CAR_REG_LIMITS) begin
						lim_q[i*8 +: 8] <= wdata[i*8 +: 8];
					end
				end
			end
			if (HUB && be[0] && reg_idx == car_pkg::CAR_REG_BUS_NUM) begin
				bus_num_q <= wdata[7:0]; // RULE14
			end
		end
	end

	// --------------------------------------------------------------
	// Read view; unmapped locations complete with zero
	// --------------------------------------------------------------
	always_comb begin
		rdata = 32'h0000_0000;
		case (reg_idx)
			car_pkg::CAR_REG_ID: rdata = {DEV_CODE, car_pkg::CAR_VENDOR_ID}; // RULE9
			car_pkg::CAR_REG_CMD: rdata = cmd_q; // RULE9
			car_pkg::CAR_REG_BUS_NUM: rdata = HUB ? {24'h00_0000, bus_num_q} : 32'h0000_0000;
			car_pkg::CAR_REG_LIMITS: rdata = HUB ? lim_q : 32'h0000_0000;
			default: rdata = 32'h0000_0000;
		endcase
	end

	assign bus_num = bus_num_q;
	assign limits = lim_q;
endmodule
`default_nettype wire

// >>> hw/car_top.sv
// Behaviour
// RULE1 - Only pointer plus data window access
// RULE2 - Pointer at 0CF8h, data window 0CFCh
// RULE3 - Dword pointer write claimed and latched
// RULE4 - Data access performs config access at pointer
// RULE5 - Hub own targets serviced inside hub
// RULE6 - Bridge own space forwarded to bridge only
// RULE7 - Other targets become bridge bus config cycles
// RULE8 - AGP buses treated like PCI buses
// RULE9 - Separate config space per chipset component
// RULE10 - Reset loads defaults into config registers
// RULE11 - Firmware programs optimal settings afterwards
// RULE12 - Pointer bit 31 enables config access
// RULE13 - Byte/word pointer access passes as I/O
// RULE14 - Bus0 device 10h is hub, holds bus number
// RULE15 - Pointer holds until next dword write
`timescale 1ns/10ps
`default_nettype none
module car_top (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Processor I/O requests
	input wire logic io_req,
	input wire logic io_we,
	input wire logic [15:0] io_addr,
	input wire logic [3:0] io_be,
	input wire logic [31:0] io_wdata,
	output logic io_ready,
	output logic io_ack,
	output logic io_claim,
	output logic [31:0] io_rdata,
	// Expander bridge requests
	output logic xb_req,
	output logic [1:0] xb_kind,
	output logic [1:0] xb_port,
	output logic xb_we,
	output logic [31:0] xb_addr,
	output logic [3:0] xb_be,
	output logic [31:0] xb_wdata,
	input wire logic xb_ack,
	input wire logic [31:0] xb_rdata
);
	logic rst_meta_q;
	logic rst_n_q;
	logic [31:0] ptr_q;
	car_pkg::car_state_e state_q;
	logic [31:0] hub_rdata;
	logic [7:0] chip_bus_num;
	logic [31:0] limits;
	logic [31:0] chip_rdata [car_pkg::CAR_NUM_CHIP];
	logic [31:0] chip_or;
	logic [car_pkg::CAR_NUM_CHIP-1:0] chip_hit;
	logic take;
	logic ptr_hit;
	logic data_hit;
	logic cfg_en;
	logic [7:0] t_bus;
	logic [4:0] t_dev;
	logic [2:0] t_fn;
	logic [5:0] t_reg;
	logic to_hub;
	logic to_chip;
	logic to_bridge;
	logic on_chip_bus;
	logic [1:0] pci_port;

	// --------------------------------------------------------------
	// Reset release
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// --------------------------------------------------------------
	// Decode of the incoming cycle
	// --------------------------------------------------------------
	assign take = io_req && io_ready && state_q == car_pkg::CAR_IDLE;
	// Only the two window locations are decoded; nothing else is a config path
	assign ptr_hit = io_addr[15:2] == car_pkg::CAR_PTR_IO[15:2]; // RULE1 RULE2
	assign data_hit = io_addr[15:2] == car_pkg::CAR_DATA_IO[15:2]; // RULE2
	assign cfg_en = ptr_q[car_pkg::CAR_PTR_EN_BIT]; // RULE12
	assign t_bus = ptr_q[car_pkg::CAR_PTR_BUS_LSB +: 8];
	assign t_dev = ptr_q[car_pkg::CAR_PTR_DEV_LSB +: 5];
	assign t_fn = ptr_q[car_pkg::CAR_PTR_FN_LSB +: 3];
	assign t_reg = ptr_q[car_pkg::CAR_PTR_REG_LSB +: 6];
	// The hub (bus zero, device 10h) wins over the chipset bus when both bus numbers are zero
	assign to_hub = t_bus == car_pkg::CAR_BUS_ZERO && t_dev == car_pkg::CAR_DEV_HUB; // RULE14
	assign on_chip_bus = t_bus == chip_bus_num && !to_hub; // RULE14
	assign to_bridge = on_chip_bus && t_dev[4:3] == car_pkg::CAR_BRIDGE_DEV_HI; // RULE6
	assign to_chip = on_chip_bus && !to_bridge;

	// Chipset component spaces, one each, function zero only
	generate
		for (genvar g = 0; g < car_pkg::CAR_NUM_CHIP; g++) begin : g_chip
			assign chip_hit[g] = t_dev == car_pkg::CAR_CHIP_DEV[g] && t_fn == car_pkg::CAR_FN_ZERO;
			car_cfg_space #(
				.DEV_CODE({11'h000, car_pkg::CAR_CHIP_DEV[g]}),
				.HUB(1'b0)
			) u_chip (
				.clk(clk),
				.rst_n(rst_n_q),
				.wr(take && data_hit && cfg_en && io_we && to_chip && chip_hit[g]), // RULE5 RULE9
				.reg_idx(t_reg),
				.be(io_be),
				.wdata(io_wdata),
				.rdata(chip_rdata[g]),
				.bus_num(),
				.limits()
			);
		end
	endgenerate

	always_comb begin
		chip_or = 32'h0000_0000;
		for (int i = 0; i < car_pkg::CAR_NUM_CHIP; i++) begin
			if (chip_hit[i]) begin
				chip_or = chip_or | chip_rdata[i];
			end
		end
	end

	car_cfg_space #(
		.DEV_CODE({11'h000, car_pkg::CAR_DEV_HUB}),
		.HUB(1'b1)
	) u_hub (
		.clk(clk),
		.rst_n(rst_n_q),
		.wr(take && data_hit && cfg_en && io_we && to_hub && t_fn == car_pkg::CAR_FN_ZERO), // RULE5
		.reg_idx(t_reg),
		.be(io_be),
		.wdata(io_wdata),
		.rdata(hub_rdata),
		.bus_num(chip_bus_num),
		.limits(limits)
	);

	// First bridge whose bus limit covers the target bus; AGP buses count alike
	always_comb begin
		pci_port = 2'h3;
		for (int i = 3; i >= 0; i--) begin
			if (t_bus <= limits[i*8 +: 8]) begin
				pci_port = 2'(i); // RULE7 RULE8
			end
		end
	end

	// --------------------------------------------------------------
	// Target pointer
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ptr_q <= car_pkg::CAR_PTR_RESET;
		end else if (take && ptr_hit && io_we && io_be == car_pkg::CAR_BE_DWORD) begin
			ptr_q <= io_wdata & car_pkg::CAR_PTR_MASK; // RULE3 RULE15
		end
	end

	// --------------------------------------------------------------
	// Cycle sequencing and downstream request
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= car_pkg::CAR_IDLE;
			io_ready <= 1'b0;
			io_ack <= 1'b0;
			io_claim <= 1'b0;
			io_rdata <= 32'h0000_0000;
			xb_req <= 1'b0;
			xb_kind <= car_pkg::CAR_KIND_IO;
			xb_port <= 2'h0;
			xb_we <= 1'b0;
			xb_addr <= 32'h0000_0000;
			xb_be <= 4'h0;
			xb_wdata <= 32'h0000_0000;
		end else begin
			io_ack <= 1'b0;
			io_claim <= 1'b0;
			case (state_q)
				car_pkg::CAR_IDLE: begin
					io_ready <= 1'b1;
					if (take) begin
						io_ready <= 1'b0;
						if (ptr_hit && io_be == car_pkg::CAR_BE_DWORD) begin
							io_ack <= 1'b1; // RULE3
							io_claim <= 1'b1;
							io_rdata <= ptr_q;
						end else if (data_hit && cfg_en && (to_hub || to_chip)) begin
							io_ack <= 1'b1; // RULE4 RULE5
							io_claim <= 1'b1;
							io_rdata <= io_we ? 32'h0000_0000 : (to_hub ? hub_rdata : chip_or);
						end else if (data_hit && cfg_en) begin
							// Bridge own space never reaches a PCI bus
							state_q <= car_pkg::CAR_WAIT; // RULE4
							xb_req <= 1'b1;
							xb_kind <= to_bridge ? car_pkg::CAR_KIND_BRIDGE : car_pkg::CAR_KIND_CFG; // RULE6 RULE7
							xb_port <= to_bridge ? t_dev[2:1] : pci_port; // RULE6 RULE7
							xb_we <= io_we;
							xb_addr <= ptr_q;
							xb_be <= io_be;
							xb_wdata <= io_wdata;
						end else begin
							// Narrow pointer access or any other I/O goes out unchanged
							state_q <= car_pkg::CAR_WAIT; // RULE13 RULE12
							xb_req <= 1'b1;
							xb_kind <= car_pkg::CAR_KIND_IO; // RULE13
							xb_port <= 2'h0;
							xb_we <= io_we;
							xb_addr <= {16'h0000, io_addr};
							xb_be <= io_be;
							xb_wdata <= io_wdata;
						end
					end
				end
				car_pkg::CAR_WAIT: begin
					// No timeout: a bridge that never answers hangs the window
					if (xb_ack) begin
						state_q <= car_pkg::CAR_IDLE;
						xb_req <= 1'b0;
						io_ack <= 1'b1; // RULE6 RULE7
						io_claim <= xb_kind != car_pkg::CAR_KIND_IO;
						io_rdata <= xb_we ? 32'h0000_0000 : xb_rdata;
						io_ready <= 1'b1;
					end
				end
				default: begin
					state_q <= car_pkg::CAR_IDLE;
					xb_req <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> shared/car_pkg.sv
package car_pkg;
	// --------------------------------------------------------------
	// I/O locations and access shape
	// --------------------------------------------------------------
	localparam logic [15:0] CAR_PTR_IO = 16'h0CF8;
	localparam logic [15:0] CAR_DATA_IO = 16'h0CFC;
	localparam logic [3:0] CAR_BE_DWORD = 4'hF;
	// --------------------------------------------------------------
	// Target pointer fields
	// --------------------------------------------------------------
	localparam int CAR_PTR_EN_BIT = 31;
	localparam int CAR_PTR_BUS_LSB = 16;
	localparam int CAR_PTR_DEV_LSB = 11;
	localparam int CAR_PTR_FN_LSB = 8;
	localparam int CAR_PTR_REG_LSB = 2;
	localparam logic [31:0] CAR_PTR_MASK = 32'h80FF_FFFC;
	localparam logic [31:0] CAR_PTR_RESET = 32'h0000_0000;
	// --------------------------------------------------------------
	// Device map
	// --------------------------------------------------------------
	localparam logic [7:0] CAR_BUS_ZERO = 8'h00;
	localparam logic [4:0] CAR_DEV_HUB = 5'h10;
	localparam int CAR_NUM_CHIP = 5;
	localparam logic [4:0] CAR_CHIP_DEV [CAR_NUM_CHIP] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06};
	localparam logic [1:0] CAR_BRIDGE_DEV_HI = 2'h2;
	localparam logic [2:0] CAR_FN_ZERO = 3'h0;
	// --------------------------------------------------------------
	// Own configuration space (dword indices)
	// --------------------------------------------------------------
	localparam logic [5:0] CAR_REG_ID = 6'h00;
	localparam logic [5:0] CAR_REG_CMD = 6'h01;
	localparam logic [5:0] CAR_REG_BUS_NUM = 6'h10;
	localparam logic [5:0] CAR_REG_LIMITS = 6'h11;
	// Identification value is arbitrary
	localparam logic [15:0] CAR_VENDOR_ID = 16'h1234;
	localparam logic [31:0] CAR_CMD_RESET = 32'h0000_0000;
	localparam logic [7:0] CAR_BUS_NUM_RESET = 8'h00;
	// Bridge 0 takes every bus by default so boot works with no setup
	localparam logic [31:0] CAR_LIMITS_RESET = 32'h0000_00FF;
	// --------------------------------------------------------------
	// Downstream request kinds
	// --------------------------------------------------------------
	localparam logic [1:0] CAR_KIND_BRIDGE = 2'h0;
	localparam logic [1:0] CAR_KIND_CFG = 2'h1;
	localparam logic [1:0] CAR_KIND_IO = 2'h2;
	typedef enum logic [1:0] {CAR_IDLE, CAR_WAIT} car_state_e;
endpackage

// >>> verif/car_bridge_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Expander bridge stand-in
// ----
module car_bridge_model (
	// Clock, reset, pace
	input wire logic clk,
	input wire logic arst_n,
	input wire logic slow,
	// Bridge request side
	input wire logic xb_req,
	input wire logic xb_we,
	input wire logic [31:0] xb_addr,
	output logic xb_ack,
	output logic [31:0] xb_rdata
);
	int wait_q;
	// Idle data keeps toggling so a stale value never passes for an answer
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xb_ack <= 1'b0;
			wait_q <= 0;
			xb_rdata <= 32'h0;
		end else if (xb_req && !xb_ack) begin
			if (wait_q >= (slow ? 3 : 0)) begin
				xb_ack <= 1'b1;
				xb_rdata <= xb_we ? 32'h0 : ~xb_addr;
			end
			wait_q <= wait_q + 1;
		end else begin
			xb_ack <= 1'b0;
			wait_q <= 0;
			xb_rdata <= ~xb_rdata;
		end
	end
endmodule
`default_nettype wire

// >>> verif/car_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checks
// ----
module car_top_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Processor side
	input wire logic io_req,
	input wire logic io_we,
	input wire logic [15:0] io_addr,
	input wire logic [3:0] io_be,
	input wire logic [31:0] io_wdata,
	input wire logic io_ready,
	input wire logic io_ack,
	input wire logic io_claim,
	input wire logic [31:0] io_rdata,
	// Bridge side
	input wire logic xb_req,
	input wire logic [1:0] xb_kind,
	input wire logic [1:0] xb_port,
	input wire logic xb_we,
	input wire logic [31:0] xb_addr,
	input wire logic [3:0] xb_be,
	input wire logic [31:0] xb_wdata,
	input wire logic xb_ack,
	input wire logic [31:0] xb_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic pw;
	assign pw = io_req && io_ready && io_we && io_addr[15:2] == car_pkg::CAR_PTR_IO[15:2];
	a_ptr_latch: assert property (pw && io_be == car_pkg::CAR_BE_DWORD |=> io_ack && io_claim && !xb_req)
		else $error("pointer write not claimed");
	a_ptr_bypass: assert property (pw && io_be != car_pkg::CAR_BE_DWORD |=> xb_req && xb_kind == car_pkg::CAR_KIND_IO)
		else $error("partial pointer write not passed on");
	a_xb_hold: assert property (xb_req && !xb_ack |=> xb_req && $stable(xb_addr) && $stable(xb_kind))
		else $error("bridge request changed early");
	a_xb_drop: assert property (xb_req && xb_ack |=> !xb_req)
		else $error("bridge request held after ack");
	a_fwd_data: assert property (xb_req && xb_ack && !xb_we |=> io_ack && io_rdata == $past(xb_rdata))
		else $error("bridge read data lost");
	a_cfg_enable: assert property (xb_req && xb_kind != car_pkg::CAR_KIND_IO |-> xb_addr[31])
		else $error("config cycle while disabled");
	a_plain_addr: assert property (xb_req && xb_kind == car_pkg::CAR_KIND_IO |-> xb_addr[31:16] == 16'h0)
		else $error("plain cycle address wrong");
	a_bridge_port: assert property (xb_req && xb_kind == car_pkg::CAR_KIND_BRIDGE |-> xb_port == xb_addr[13:12] && xb_addr[15:14] == 2'h2)
		else $error("bridge space port wrong");
	a_xb_copy: assert property ($rose(xb_req) |-> xb_we == $past(io_we) && xb_be == $past(io_be) && xb_wdata == $past(io_wdata))
		else $error("bridge request fields not copied");
	c_ptr: cover property (pw);
	c_bridge: cover property (xb_ack && xb_kind == car_pkg::CAR_KIND_BRIDGE);
	c_cfg: cover property (xb_ack && xb_kind == car_pkg::CAR_KIND_CFG);
endmodule
bind car_top car_top_chk chk_u (.clk, .arst_n, .io_req, .io_we, .io_addr, .io_be, .io_wdata,
	.io_ready, .io_ack, .io_claim, .io_rdata, .xb_req, .xb_kind, .xb_port, .xb_we, .xb_addr,
	.xb_be, .xb_wdata, .xb_ack, .xb_rdata);
`default_nettype wire

// >>> verif/config_access_router_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Bench
// ----
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module config_access_router_tb;
	typedef struct {logic c; logic [31:0] d, m;} car_io_s;
	typedef struct {logic [1:0] k, p; logic [31:0] a;} car_xb_s;
	logic clk = 0, arst_n = 0, io_req = 0, io_we = 0, slow = 0;
	logic [15:0] io_addr = 16'h0;
	logic [3:0] io_be = 4'h0;
	logic [31:0] io_wdata = 32'h0, v, a;
	logic io_ready, io_ack, io_claim, xb_req, xb_we, xb_ack;
	logic [1:0] xb_kind, xb_port;
	logic [3:0] xb_be;
	logic [31:0] io_rdata, xb_addr, xb_wdata, xb_rdata;
	logic [7:0] bus_tbl [3] = '{8'h06, 8'h15, 8'h40};
	int failures = 0, n_checks = 0, cyc = 0, seed = 32'h934AC4F1;
	car_io_s iq[$];
	car_xb_s xq[$];
	always #2 clk = ~clk;
	car_top dut_u (.clk, .arst_n, .io_req, .io_we, .io_addr, .io_be, .io_wdata, .io_ready, .io_ack,
		.io_claim, .io_rdata, .xb_req, .xb_kind, .xb_port, .xb_we, .xb_addr, .xb_be, .xb_wdata,
		.xb_ack, .xb_rdata);
	car_bridge_model bm_u (.clk, .arst_n, .slow, .xb_req, .xb_we, .xb_addr, .xb_ack, .xb_rdata);
	task automatic final_report;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Request held until the edge that samples ready high
	task automatic io(input logic w, input logic [15:0] ad, input logic [3:0] be,
		input logic [31:0] wd, input logic c, input logic [31:0] d, input logic [31:0] m);
		iq.push_back('{c, d & m, m});
		io_req <= 1'b1;
		io_we <= w;
		io_addr <= ad;
		io_be <= be;
		io_wdata <= wd;
		slow <= 1'($random(seed));
		do @(posedge clk); while (io_ready !== 1'b1);
		io_req <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wp(input logic [31:0] p);
		io(1'b1, car_pkg::CAR_PTR_IO, car_pkg::CAR_BE_DWORD, p, 1'b1, 32'h0, 32'h0);
	endtask
	task automatic dw(input logic w, input logic [31:0] wd, input logic c, input logic [31:0] d);
		io(w, car_pkg::CAR_DATA_IO, car_pkg::CAR_BE_DWORD, wd, c, d, w ? 32'h0 : 32'hFFFF_FFFF);
	endtask
	function automatic logic [31:0] pa(input logic [7:0] b, input logic [4:0] dv, input logic [5:0] r);
		return {1'b1, 7'h00, b, dv, 3'h0, r, 2'h0};
	endfunction
	always @(posedge clk) begin
		if (io_ack === 1'b1) begin
			`CHK(io_claim, iq[0].c)
			`CHK(io_rdata & iq[0].m, iq[0].d)
			void'(iq.pop_front());
		end
		if (xb_req === 1'b1 && xb_ack === 1'b1) begin
			`CHK({xb_kind, xb_addr}, {xq[0].k, xq[0].a})
			if (xq[0].k != car_pkg::CAR_KIND_IO) `CHK(xb_port, xq[0].p)
			void'(xq.pop_front());
		end
	end
	always @(posedge clk) if (++cyc > 4000) begin failures++; final_report(); end
	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		io(1'b0, car_pkg::CAR_PTR_IO, 4'hF, 32'h0, 1'b1, car_pkg::CAR_PTR_RESET, '1);
		v = $random(seed);
		wp(v);
		io(1'b0, car_pkg::CAR_PTR_IO, 4'hF, 32'h0, 1'b1, v & car_pkg::CAR_PTR_MASK, '1);
		xq.push_back('{car_pkg::CAR_KIND_IO, 2'h0, {16'h0, car_pkg::CAR_PTR_IO}});
		io(1'b1, car_pkg::CAR_PTR_IO, 4'h1, $random(seed), 1'b0, 32'h0, 32'h0);
		io(1'b0, car_pkg::CAR_PTR_IO, 4'hF, 32'h0, 1'b1, v & car_pkg::CAR_PTR_MASK, '1);
		wp(v & 32'h7FFF_FFFF);
		xq.push_back('{car_pkg::CAR_KIND_IO, 2'h0, {16'h0, car_pkg::CAR_DATA_IO}});
		dw(1'b0, 32'h0, 1'b0, ~{16'h0, car_pkg::CAR_DATA_IO});
		wp(pa(8'h0, car_pkg::CAR_DEV_HUB, car_pkg::CAR_REG_ID));
		io(1'b0, car_pkg::CAR_DATA_IO, 4'hF, 0, 1'b1, car_pkg::CAR_VENDOR_ID, 32'hFFFF);
		wp(pa(8'h0, car_pkg::CAR_DEV_HUB, car_pkg::CAR_REG_LIMITS));
		dw(1'b0, 32'h0, 1'b1, car_pkg::CAR_LIMITS_RESET);
		dw(1'b1, 32'hFFFF_2010, 1'b1, 32'h0);
		wp(pa(8'h0, car_pkg::CAR_DEV_HUB, car_pkg::CAR_REG_CMD));
		dw(1'b0, 32'h0, 1'b1, car_pkg::CAR_CMD_RESET);
		dw(1'b1, v, 1'b1, 32'h0);
		dw(1'b0, 32'h0, 1'b1, v);
		wp(pa(8'h0, car_pkg::CAR_DEV_HUB, car_pkg::CAR_REG_BUS_NUM));
		dw(1'b0, 32'h0, 1'b1, {24'h0, car_pkg::CAR_BUS_NUM_RESET});
		dw(1'b1, 32'h05, 1'b1, 32'h0);
		wp(pa(8'h05, car_pkg::CAR_CHIP_DEV[2], car_pkg::CAR_REG_ID));
		dw(1'b0, 32'h0, 1'b1, {11'h000, car_pkg::CAR_CHIP_DEV[2], car_pkg::CAR_VENDOR_ID});
		wp(pa(8'h05, car_pkg::CAR_CHIP_DEV[4], car_pkg::CAR_REG_CMD));
		dw(1'b1, ~v, 1'b1, 32'h0);
		dw(1'b0, 32'h0, 1'b1, ~v);
		wp(pa(8'h05, 5'h02, car_pkg::CAR_REG_CMD));
		dw(1'b0, 32'h0, 1'b1, 32'h0);
		wp(pa(8'h0, car_pkg::CAR_DEV_HUB, car_pkg::CAR_REG_CMD));
		dw(1'b0, 32'h0, 1'b1, v);
		for (int p = 0; p < 4; p++) begin
			a = pa(8'h05, 5'(8'h10 + 2 * p), 6'($random(seed)));
			xq.push_back('{car_pkg::CAR_KIND_BRIDGE, 2'(p), a});
			wp(a);
			dw(1'b0, 32'h0, 1'b1, ~a);
		end
		for (int i = 0; i < 3; i++) begin
			a = pa(bus_tbl[i], 5'($random(seed)), 6'($random(seed)));
			xq.push_back('{car_pkg::CAR_KIND_CFG, 2'(i), a});
			xq.push_back('{car_pkg::CAR_KIND_CFG, 2'(i), a});
			wp(a);
			dw(1'b0, 32'h0, 1'b1, ~a);
			dw(1'b1, $random(seed), 1'b1, 32'h0);
		end
		repeat (8) @(posedge clk);
		`CHK(iq.size() + xq.size(), 0)
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		io(1'b0, car_pkg::CAR_PTR_IO, 4'hF, 32'h0, 1'b1, car_pkg::CAR_PTR_RESET, '1);
		wp(pa(8'h0, car_pkg::CAR_DEV_HUB, car_pkg::CAR_REG_LIMITS));
		dw(1'b0, 32'h0, 1'b1, car_pkg::CAR_LIMITS_RESET);
		repeat (8) @(posedge clk);
		`CHK(iq.size() + xq.size(), 0)
		final_report();
	end
endmodule
`default_nettype wire
